// file: logic/dsb_regs.vh
`ifndef DSB_REGS_VH
`define DSB_REGS_VH

// system channel command codes
`define DSB_CMD_W            8
`define DSB_CMD_BUS_RESET    8'h01
`define DSB_CMD_DEVICE_SCAN  8'h02

// framing
`define DSB_QUADLET_BITS     8'h20
`define DSB_FRAME_BITS_DEF   16'h0200
`define DSB_SYNC_PATTERN_DEF 32'h5A5A_A5A5

// bus clock idle detection
`define DSB_REF_CLK_MHZ      200
`define DSB_IDLE_TIME_NS     1000
// 1000 ns of a still bus clock at 200 MHz, sized to the idle counter
`define DSB_IDLE_CYCLES      16'h00C8

// reset values
`define DSB_ZERO_CH          8'h00
`define DSB_ZERO_STATUS      32'h0000_0000

`endif

// file: logic/dsb_sync.v
`timescale 1ns/10ps
`default_nettype none

module dsb_sync #(
	parameter W = 2
) (
	input  wire         ref_clk,
	input  wire         rst_b,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			meta_reg <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // dsb_sync

`default_nettype wire

// file: logic/dsb_device.v
// Notes on behaviour
// - the controller may broadcast a bus reset command on the system channel, all commands optional.
// - on a bus reset command the device aborts any transfer in progress and empties its buffers.
// - a device scan command naming this device identifier is answered so the host learns it exists.
// - the controller supplies the bus clock and keeps running while its network is unlocked.
// - with no bus activity the controller may stop the bus clock, putting the bus in low power.
// - channel identifier assignments survive low power and are valid at once on clock restart.
// - the device runs synchronously from the controller driven bus clock; here it runs on ref_clk and acts on synchronized bus clock rises.
// - after the bus clock starts the device must reach frame lock before communicating.
// - while unlocked the device hunts for the frame sync pattern, a byte and channel boundary.
// - the first physical channel begins exactly one quadlet after the frame sync pattern.
// - with overflow enable set and flow control off, an iso rx overflow sets its channel status bit.
// - with protocol error enable set, an iso rx protocol error sets its channel status bit.
`timescale 1ns/10ps
`default_nettype none
`include "dsb_regs.vh"

module dsb_device #(
	parameter        DEV_ID_W    = 8,
	parameter [7:0]  DEVICE_ID   = 8'h10,
	parameter        SYNC_W      = 32,
	parameter [31:0] SYNC_PAT    = `DSB_SYNC_PATTERN_DEF,
	parameter [15:0] FRAME_BITS  = `DSB_FRAME_BITS_DEF,
	parameter        IDX_W       = 4,
	parameter        CID_W       = 8
) (
	input  wire                 ref_clk,
	input  wire                 rst_b,
	input  wire                 bus_clock_signal,
	input  wire                 bus_data_pin,
	input  wire                 sys_cmd_valid,
	input  wire [`DSB_CMD_W-1:0] sys_cmd_code,
	input  wire [DEV_ID_W-1:0]  sys_cmd_device_identifier,
	input  wire                 cfg_valid,
	input  wire [IDX_W-1:0]     cfg_index,
	input  wire [CID_W-1:0]     cfg_channel_identifier,
	input  wire [IDX_W-1:0]     cid_rd_index,
	input  wire                 iso_rx_overflow_enable,
	input  wire                 iso_rx_protocol_error_enable,
	input  wire                 iso_flow_control_on,
	input  wire [63:0]          iso_overflow_evt,
	input  wire [63:0]          iso_protocol_error_evt,
	input  wire [63:0]          status_clear,
	output reg                  scan_answer,
	output reg                  transfer_abort,
	output reg                  buffer_flush,
	output reg                  bus_low_power,
	output reg                  frame_locked,
	output wire                 comm_enable,
	output reg                  first_physical_channel,
	output reg                  channel_boundary,
	output reg  [CID_W-1:0]     cid_rd_value,
	output reg  [31:0]          channel_status_low,
	output reg  [31:0]          channel_status_high
);

	localparam [15:0] IDLE_CYCLES = `DSB_IDLE_CYCLES;
	localparam NCID = 1 << IDX_W;
	// the pattern ends one quadlet before the next frame's first channel
	localparam [15:0] SYNC_AT = FRAME_BITS - {8'h00, `DSB_QUADLET_BITS} - 16'h0001;

	// frame search states, one-hot
	localparam [2:0] ST_HUNT  = 3'b001;
	localparam [2:0] ST_FIRST = 3'b010;
	localparam [2:0] ST_LOCK  = 3'b100;

	wire [1:0] pin_sync;
	reg        bclk_d_reg;
	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg [SYNC_W-1:0] shift_reg;
	reg [15:0] bit_cnt_reg;
	reg [15:0] idle_cnt_reg;
	reg [CID_W-1:0] cid_table [0:NCID-1];
	integer i;

	// both pins sampled as plain inputs; the bus clock is only edge-detected
	dsb_sync #(
		.W        (2)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.async_in ({bus_clock_signal, bus_data_pin}),
		.sync_out (pin_sync)
	);

	wire bclk_rise = pin_sync[1] & ~bclk_d_reg;
	wire [SYNC_W-1:0] shift_next = {shift_reg[SYNC_W-2:0], pin_sync[0]};
	wire pattern_hit = (shift_next == SYNC_PAT[SYNC_W-1:0]);

	function [63:0] status_update;
		input [63:0] cur;
		input [63:0] ovf;
		input [63:0] pe;
		input [63:0] clr;
		input        ovf_en;
		input        pe_en;
		input        flow_on;
		reg   [63:0] set_mask;
		begin
			set_mask = {64{1'b0}};
			if (ovf_en && !flow_on)
				set_mask = set_mask | ovf;
			if (pe_en)
				set_mask = set_mask | pe;
			// disabled events add nothing and set beats clear
			status_update = (cur & ~clr) | set_mask;
		end
	endfunction

	wire [63:0] status_next = status_update({channel_status_high, channel_status_low},
		iso_overflow_evt, iso_protocol_error_evt, status_clear,
		iso_rx_overflow_enable, iso_rx_protocol_error_enable, iso_flow_control_on);

	assign comm_enable = frame_locked & ~bus_low_power;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_HUNT: begin
				if (bclk_rise && pattern_hit)
					state_next = ST_FIRST;
			end
			ST_FIRST: begin
				if (bclk_rise && bit_cnt_reg == `DSB_QUADLET_BITS - 8'h01)
					state_next = ST_LOCK;
			end
			ST_LOCK: begin
				if (bclk_rise && bit_cnt_reg == SYNC_AT && !pattern_hit)
					state_next = ST_HUNT;
			end
			default: state_next = ST_HUNT;
		endcase
		// a stopped clock means relock after restart
		if (idle_cnt_reg >= IDLE_CYCLES)
			state_next = ST_HUNT;
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			bclk_d_reg             <= 1'b0;
			state_reg              <= ST_HUNT;
			shift_reg              <= {SYNC_W{1'b0}};
			bit_cnt_reg            <= 16'h0000;
			idle_cnt_reg           <= 16'h0000;
			bus_low_power          <= 1'b0;
			frame_locked           <= 1'b0;
			first_physical_channel <= 1'b0;
			channel_boundary       <= 1'b0;
			scan_answer            <= 1'b0;
			transfer_abort         <= 1'b0;
			buffer_flush           <= 1'b0;
			cid_rd_value           <= `DSB_ZERO_CH;
			channel_status_low     <= `DSB_ZERO_STATUS;
			channel_status_high    <= `DSB_ZERO_STATUS;
			for (i = 0; i < NCID; i = i + 1)
				cid_table[i] <= `DSB_ZERO_CH;
		end else begin
			bclk_d_reg             <= pin_sync[1];
			state_reg              <= state_next;
			first_physical_channel <= 1'b0;
			channel_boundary       <= 1'b0;
			frame_locked           <= (state_next == ST_LOCK);

			// idle watch: counts only while the bus clock is still
			if (bclk_rise) begin
				idle_cnt_reg  <= 16'h0000;
				bus_low_power <= 1'b0;
			end else if (idle_cnt_reg < IDLE_CYCLES) begin
				idle_cnt_reg <= idle_cnt_reg + 16'h0001;
			end else begin
				bus_low_power <= 1'b1;
			end

			if (bclk_rise) begin
				shift_reg <= shift_next;
				case (state_reg)
					ST_HUNT: begin
						bit_cnt_reg <= 16'h0000;
					end
					ST_FIRST: begin
						if (bit_cnt_reg == `DSB_QUADLET_BITS - 8'h01) begin
							bit_cnt_reg            <= 16'h0000;
							first_physical_channel <= 1'b1;
							channel_boundary       <= 1'b1;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 16'h0001;
						end
					end
					ST_LOCK: begin
						if (bit_cnt_reg == FRAME_BITS - 16'h0001) begin
							bit_cnt_reg            <= 16'h0000;
							first_physical_channel <= 1'b1;
							channel_boundary       <= 1'b1;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 16'h0001;
							if (bit_cnt_reg[4:0] == 5'h1f)
								channel_boundary <= 1'b1;
						end
					end
					default: bit_cnt_reg <= 16'h0000;
				endcase
			end

			// system channel; every command is optional for the controller
			scan_answer    <= sys_cmd_valid && sys_cmd_code == `DSB_CMD_DEVICE_SCAN
				&& sys_cmd_device_identifier == DEVICE_ID;
			transfer_abort <= sys_cmd_valid && sys_cmd_code == `DSB_CMD_BUS_RESET;
			buffer_flush   <= sys_cmd_valid && sys_cmd_code == `DSB_CMD_BUS_RESET;

			// table untouched by low power or bus reset, so paths hold on restart
			if (cfg_valid)
				cid_table[cfg_index] <= cfg_channel_identifier;
			cid_rd_value <= cid_table[cid_rd_index];

			{channel_status_high, channel_status_low} <= status_next;
		end
	end

endmodule // dsb_device

`default_nettype wire

// file: logic/dsb_unused_placeholder_none.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: testbench/dsb_device_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsb_regs.vh"
module dsb_device_chk #(parameter [7:0] DEVICE_ID = 8'h10) (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        sys_cmd_valid,
	input wire logic        iso_flow_control_on,
	input wire logic [7:0]  sys_cmd_code,
	input wire logic [7:0]  sys_cmd_device_identifier,
	input wire logic        iso_rx_overflow_enable,
	input wire logic        iso_rx_protocol_error_enable,
	input wire logic        scan_answer,
	input wire logic        transfer_abort,
	input wire logic        buffer_flush,
	input wire logic        bus_low_power,
	input wire logic        frame_locked,
	input wire logic        comm_enable,
	input wire logic        first_physical_channel,
	input wire logic        channel_boundary,
	input wire logic [63:0] iso_overflow_evt,
	input wire logic [63:0] iso_protocol_error_evt,
	input wire logic [63:0] status_clear,
	input wire logic [31:0] channel_status_low,
	input wire logic [31:0] channel_status_high
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire logic [63:0] st = {channel_status_high, channel_status_low};
	a_scan_answer: assert property (sys_cmd_valid && sys_cmd_code == `DSB_CMD_DEVICE_SCAN
		&& sys_cmd_device_identifier == DEVICE_ID |=> scan_answer) else $error("scan");
	a_reset_abort: assert property (sys_cmd_valid && sys_cmd_code == `DSB_CMD_BUS_RESET
		|=> transfer_abort && buffer_flush) else $error("abort");
	a_comm_locked: assert property (comm_enable |-> frame_locked) else $error("comm");
	a_lock_start: assert property ($rose(frame_locked) |-> first_physical_channel)
		else $error("lock");
	a_first_chan: assert property (first_physical_channel |-> channel_boundary)
		else $error("first");
	a_idle_unlock: assert property (bus_low_power |=> !frame_locked) else $error("idle");
	a_ovf_sets: assert property (iso_rx_overflow_enable && !iso_flow_control_on
		|=> (st & $past(iso_overflow_evt)) == $past(iso_overflow_evt)) else $error("ovf");
	a_perr_sets: assert property (iso_rx_protocol_error_enable
		|=> (st & $past(iso_protocol_error_evt)) == $past(iso_protocol_error_evt)) else $error("pe");
	a_status_hold: assert property (!iso_rx_overflow_enable && !iso_rx_protocol_error_enable
		&& status_clear == 64'h0 |=> st == $past(st)) else $error("hold");
	c_scan: cover property (scan_answer);
	c_lock: cover property ($rose(frame_locked));
	c_idle: cover property (bus_low_power);
endmodule // dsb_device_chk
bind dsb_device dsb_device_chk #(.DEVICE_ID(DEVICE_ID)) u_chk (.*);
`default_nettype wire

// file: testbench/dsb_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsb_ctrl_model #(parameter [31:0] PAT = 32'h5A5A_A5A5, parameter int NB = 512) (
	input  wire logic run,
	output var logic  bus_clock_signal,
	output var logic  bus_data_pin,
	output var int    n_rise
);
	// clock runs frames back to back and stands still only while run is low; idle data toggles so no stale level is trusted
	initial begin
		bus_clock_signal = 0;
		bus_data_pin = 0;
		n_rise = 0;
		forever begin
			if (run !== 1'b1) begin
				bus_data_pin = ~bus_data_pin;
				#62.5;
			end else begin
				for (int i = 0; i < NB; i++) begin
					bus_data_pin = (i < 32) ? PAT[31 - i] : i[0];
					#62.5 bus_clock_signal = 1;
					n_rise++;
					#62.5 bus_clock_signal = 0;
				end
			end
		end
	end
endmodule // dsb_ctrl_model
`default_nettype wire

// file: testbench/serial_device_bus_init_sync_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsb_regs.vh"
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module serial_device_bus_init_sync_tb_top;
	logic        ref_clk, rst_b, sys_cmd_valid, cfg_valid, run, bus_clock_signal, bus_data_pin;
	logic        iso_rx_overflow_enable, iso_rx_protocol_error_enable, iso_flow_control_on;
	logic [7:0]  sys_cmd_code, sys_cmd_device_identifier, cfg_channel_identifier, cid_rd_value;
	logic [3:0]  cfg_index, cid_rd_index;
	logic [63:0] iso_overflow_evt, iso_protocol_error_evt, status_clear, exp_st, o, p, cl;
	logic        scan_answer, transfer_abort, buffer_flush, bus_low_power, frame_locked;
	logic        comm_enable, first_physical_channel, channel_boundary;
	logic [31:0] channel_status_low, channel_status_high;
	logic [7:0]  cid_exp;
	logic [2:0]  r;
	int          fails = 0, n_checks = 0, n_rise, n_bnd = 0, b0;
	dsb_device uut (.*);
	dsb_ctrl_model bus (.*);
	initial begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// free-running count of quadlet boundaries; scenarios take differences
	always @(posedge ref_clk) begin
		if (channel_boundary === 1'b1) n_bnd <= n_bnd + 1;
	end
	task automatic results();
		$display("fails %0d checks %0d", fails, n_checks);
		if (fails == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] d);
		@(posedge ref_clk);
		{sys_cmd_valid, sys_cmd_code, sys_cmd_device_identifier} <= {1'b1, c, d};
		@(posedge ref_clk);
		sys_cmd_valid <= 0;
		#1 `CHK("scan", c == `DSB_CMD_DEVICE_SCAN && d == 8'h10, scan_answer)
		`CHK("abort", c == `DSB_CMD_BUS_RESET, transfer_abort)
		`CHK("flush", c == `DSB_CMD_BUS_RESET, buffer_flush)
	endtask
	// bounded wait; a frame can take 12800 cycles to drain before the clock stops
	// sel 0 waits for the first channel pulse, any other value for low power
	task automatic wait_on(input int sel);
		int i;
		for (i = 0; i < 20000; i++) begin
			@(posedge ref_clk);
			#1;
			if ((sel == 0 ? first_physical_channel : bus_low_power) === 1'b1) break;
		end
		if (i == 20000) begin
			fails++;
			results();
		end
	endtask
	initial begin
		{sys_cmd_valid, cfg_valid, run, r} = 0;
		{iso_rx_overflow_enable, iso_rx_protocol_error_enable, iso_flow_control_on} = 0;
		{sys_cmd_code, sys_cmd_device_identifier, cfg_index, cfg_channel_identifier} = 0;
		{iso_overflow_evt, iso_protocol_error_evt, status_clear, cid_rd_index} = 0;
		exp_st = 64'h0;
		rst_b = 0;
		void'($urandom(32'hd6c1));
		repeat (2) @(posedge ref_clk);
		rst_b <= 1;
		cmd(`DSB_CMD_DEVICE_SCAN, 8'h10);
		cmd(`DSB_CMD_DEVICE_SCAN, 8'h11);
		cmd(`DSB_CMD_BUS_RESET, 8'h10);
		cmd(8'h03, 8'h10);
		cid_exp = $urandom;
		@(posedge ref_clk);
		{cfg_valid, cfg_index, cfg_channel_identifier} <= {1'b1, 4'h3, cid_exp};
		@(posedge ref_clk);
		cfg_valid <= 0;
		cid_rd_index <= 4'h3;
		for (int k = 0; k < 24; k++) begin
			r = $urandom;
			o = 64'h1 << $urandom_range(63);
			p = 64'h1 << $urandom_range(63);
			cl = (k % 3 == 2) ? exp_st : 64'h0;
			@(posedge ref_clk);
			{iso_rx_overflow_enable, iso_rx_protocol_error_enable, iso_flow_control_on} <= r;
			{iso_overflow_evt, iso_protocol_error_evt, status_clear} <= {o, p, cl};
			exp_st = (exp_st & ~cl) | (r[2] && !r[0] ? o : 64'h0) | (r[1] ? p : 64'h0);
			@(posedge ref_clk);
			{iso_overflow_evt, iso_protocol_error_evt, status_clear} <= 192'h0;
			#1 `CHK("status", exp_st, {channel_status_high, channel_status_low})
		end
		@(posedge ref_clk);
		run <= 1;
		wait_on(0);
		b0 = n_bnd;
		`CHK("rises", 64, n_rise)
		`CHK("locked", 1'b1, frame_locked && comm_enable)
		// a second frame must keep the lock and bring the next first channel
		wait_on(0);
		`CHK("frame_rises", `DSB_FRAME_BITS_DEF + 64, n_rise)
		`CHK("bounds", `DSB_FRAME_BITS_DEF / `DSB_QUADLET_BITS, n_bnd - b0)
		`CHK("held", 1'b1, frame_locked)
		run <= 0;
		wait_on(1);
		`CHK("unlock", 1'b0, frame_locked)
		`CHK("comm_off", 1'b0, comm_enable)
		`CHK("table", cid_exp, cid_rd_value)
		@(posedge ref_clk);
		run <= 1;
		wait_on(0);
		`CHK("relock", cid_exp, cid_rd_value)
		`CHK("relocked", 1'b1, frame_locked)
		results();
	end
endmodule // serial_device_bus_init_sync_tb_top
`default_nettype wire
